// >>> dv/channel_indirect_data_addressing_tb.sv
/*
 * Bench for the channel engine: register tasks, command lists in storage.
 * Assumes the storage model and a device stub in this module.
 */
module channel_indirect_data_addressing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, mem_ack_i;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, mem_rdata_i, rd;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = 0;
  logic hreadyout_o, hresp_o, dev_ack_i = 0, dev_in_ready_o, irq_o;
  logic dev_in_valid_i = 0, dev_end_i = 0, end_arm = 0;
  logic [7:0] dev_in_data_i = 8'hA0, dev_cmd_o, wr_byte = 0;
  cida_pkg::cida_mem_req_t mem_o;
  cida_pkg::cida_dev_out_t dev_out_o;
  int mismatches = 0, tests_run = 0, cycles = 0, n;
  cida_channel i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .dev_cmd_o(dev_cmd_o), .dev_out_o(dev_out_o), .dev_ack_i(dev_ack_i),
    .dev_in_ready_o(dev_in_ready_o), .dev_in_valid_i(dev_in_valid_i),
    .dev_in_data_i(dev_in_data_i), .dev_end_i(dev_end_i), .irq_o(irq_o));
  cida_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  initial forever #12.5 clk_i = ~clk_i;
  // ****************************************
  // Cycle timeout and device stub
  // ****************************************
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  always @(posedge clk_i) begin
    if (dev_in_ready_o && dev_in_valid_i) dev_in_data_i <= dev_in_data_i + 1;
    dev_in_valid_i <= dev_in_ready_o && !dev_in_valid_i;
    dev_end_i <= dev_in_ready_o && end_arm && !dev_end_i;
    dev_ack_i <= dev_out_o.valid && !dev_ack_i;
    if (dev_out_o.valid && dev_ack_i) wr_byte <= dev_out_o.data;
  end
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1; htrans_i <= 2'h2; haddr_i <= {24'h00_0000, a};
    hwrite_i <= w; hsize_i <= 3'h2;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 0; htrans_i <= 2'h0; hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : ahb
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      mismatches = mismatches + 1;
    end
  endtask : chk
  task run(input logic [31:0] ptr);
    ahb(1, cida_pkg::CLPW_OFS, ptr);
    ahb(1, cida_pkg::CTRL_OFS, 32'h0000_0003);
    n = 0;
    while (irq_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n = n + 1;
    end
    chk("irq", 32'h1, irq_o);
  endtask : run
  task complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    // Read with list, crossing at 0x800, chained to a direct write
    i_mem.put_w(14'h0100, 32'h0200_0200);
    i_mem.put_w(14'h0104, 32'h4400_0004);
    i_mem.put_w(14'h0108, 32'h0100_2000);
    i_mem.put_w(14'h010C, 32'h0000_0001);
    i_mem.put_w(14'h0200, 32'h0000_07FE);
    i_mem.put_w(14'h0204, 32'h0000_1000);
    i_mem.put_w(14'h2000, 32'h5A00_0000);
    // Second list word off the block start
    i_mem.put_w(14'h0120, 32'h0200_0300);
    i_mem.put_w(14'h0124, 32'h0400_0004);
    i_mem.put_w(14'h0300, 32'h0000_07FF);
    i_mem.put_w(14'h0304, 32'h0000_1004);
    i_mem.put_w(14'h0800, 32'h0000_0000);
    i_mem.put_w(14'h1000, 32'h0000_0000);
    // Read backward, second word on a block end
    i_mem.put_w(14'h0140, 32'h0C00_0340);
    i_mem.put_w(14'h0144, 32'h0400_0002);
    i_mem.put_w(14'h0340, 32'h0000_1800);
    i_mem.put_w(14'h0344, 32'h0000_0FFF);
    // Direct read that the device ends early
    i_mem.put_w(14'h0160, 32'h0200_0600);
    i_mem.put_w(14'h0164, 32'h0000_0005);
    i_mem.put_w(14'h0600, 32'h0000_0000);
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    ahb(0, cida_pkg::CTRL_OFS, 0); chk("ctrl", 32'h0000_0002, rd);
    ahb(0, cida_pkg::IRQ_MASK_OFS, 0); chk("mask", 32'h0000_0000, rd);
    ahb(0, 8'h40, 0); chk("unmapped", 32'h0000_0000, rd);
    chk("hresp", 32'h0, hresp_o);
    ahb(1, cida_pkg::IRQ_MASK_OFS, 32'h0000_0003);
    run(32'h0000_0100);
    ahb(0, cida_pkg::IRQ_STAT_OFS, 0); chk("irq stat", 32'h0000_0005, rd);
    chk("b7fe", 32'hA0, i_mem.mem[14'h07FE]);
    chk("b7ff", 32'hA1, i_mem.mem[14'h07FF]);
    chk("b800", 32'h00, i_mem.mem[14'h0800]);
    chk("b1000", 32'hA2, i_mem.mem[14'h1000]);
    chk("b1001", 32'hA3, i_mem.mem[14'h1001]);
    chk("b1002", 32'h00, i_mem.mem[14'h1002]);
    chk("write byte", 32'h5A, wr_byte);
    ahb(1, cida_pkg::IRQ_STAT_OFS, 32'h0000_0007);
    run(32'h0000_0120);
    ahb(0, cida_pkg::IRQ_STAT_OFS, 0); chk("pchk", 32'h2, rd & 32'h2);
    ahb(0, cida_pkg::STATUS_OFS, 0); chk("cause", 32'h4, rd[6:4]);
    ahb(0, cida_pkg::CUR_ADDR_OFS, 0); chk("cur", 32'h800, rd);
    chk("cmd", 32'h0000_0002, dev_cmd_o);
    ahb(1, cida_pkg::IRQ_STAT_OFS, 32'h0000_0007);
    run(32'h0000_0140);
    ahb(0, cida_pkg::IRQ_STAT_OFS, 0); chk("back irq", 32'h5, rd);
    chk("b1800", 32'hA5, i_mem.mem[14'h1800]);
    chk("b0fff", 32'hA6, i_mem.mem[14'h0FFF]);
    ahb(1, cida_pkg::IRQ_STAT_OFS, 32'h0000_0007);
    end_arm <= 1'b1;
    run(32'h0000_0160);
    ahb(0, cida_pkg::COUNT_OFS, 0); chk("residual", 32'h5, rd);
    chk("b600", 32'h00, i_mem.mem[14'h0600]);
    ahb(1, cida_pkg::IRQ_MASK_OFS, 0);
    @(posedge clk_i);
    @(posedge clk_i);
    chk("irq masked", 32'h0, irq_o);
    complete_run();
  end
endmodule : channel_indirect_data_addressing_tb

// >>> dv/cida_mem_model.sv
/*
 * Real storage model answering the channel storage port.
 * Assumes byte array at real addresses, ack after three request cycles.
 */
module cida_mem_model (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Storage port
  input  cida_pkg::cida_mem_req_t mem_i,
  output logic                   ack_o,
  output logic [31:0]            rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:16383];
  logic [1:0]  cnt;
  logic [13:0] a;
  assign a = mem_i.addr[13:0];
  // ****************************************
  // Acknowledge and data, addresses taken as real
  // ****************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt   <= 2'h0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (mem_i.req && !ack_o) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h2) begin
          cnt   <= 2'h0;
          ack_o <= 1'b1;
          if (mem_i.we) mem[a] <= mem_i.wdata;
          else if (mem_i.is_byte) rdata_o <= {24'h00_0000, mem[a]};
          else rdata_o <= {mem[a], mem[a+1], mem[a+2], mem[a+3]};
        end
      end
    end
  end
  task put_w(input logic [13:0] ad, input logic [31:0] d);
    {mem[ad], mem[ad+1], mem[ad+2], mem[ad+3]} = d;
  endtask : put_w
endmodule : cida_mem_model

// >>> hw/cida_channel.sv
/*
 * Channel data engine with indirect data addressing and AHB-Lite
 * register slave.
 * Assumes a storage port that answers each held request with one
 * mem_ack_i cycle and a device byte port synchronous to clk_i.
 */
// How it works
// R1: Command word bit 37 is the indirect flag when the feature is on.
// R2: Flag honoured for read, read backward, write, control, sense, any mode.
// R3: Flag clear: address field is the data start address.
// R4: Flag set: address field points at an indirect list.
// R5: Software lays list words contiguously, one per 2K block.
// R6: List words are word aligned with top byte zero.
// R7: First list word may hold any address.
// R8: Later list words must sit on block start, or end for backward.
// R9: Start fetches first command word at pointer word address.
// R10: Flag set: fetch first list word, transfer from its address.
// R11: Forward transfers count upward until the block boundary.
// R12: Low 11 address bits wrapping to zero fetch the next list word.
// R13: List use ends when count is zero or device ends.
// R14: Chaining fetches next command word and rechecks its flag.
// R15: All addresses are real; no translation is done.
// R16: Software sets flag only when the area spans pages.
// R17: Read backward counts down; wrap to all ones fetches next word.
// R18: List words are fetched four bytes apart from the list start.
module cida_channel #(
  parameter int CNT_W = cida_pkg::CCW_CNT_W
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // Real storage port
  output cida_pkg::cida_mem_req_t    mem_o,
  input  wire logic                  mem_ack_i,
  input  wire logic [31:0]           mem_rdata_i,
  // Device byte port
  output logic      [7:0]            dev_cmd_o,
  output cida_pkg::cida_dev_out_t    dev_out_o,
  input  wire logic                  dev_ack_i,
  output logic                       dev_in_ready_o,
  input  wire logic                  dev_in_valid_i,
  input  wire logic [7:0]            dev_in_data_i,
  input  wire logic                  dev_end_i,
  // Interrupt
  output logic                       irq_o
);

  localparam int AW      = cida_pkg::ADDR_W;
  localparam int IRQ_W_L = cida_pkg::IRQ_W;

  // Counter must fit the command word count field
  if (CNT_W < 1 || CNT_W > cida_pkg::CCW_CNT_W) begin : g_cnt_w_chk
    $error("CNT_W out of range");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic blk_edge(input logic [AW-1:0] a,
                                    input logic ones);
    blk_edge = ones ? (&a[cida_pkg::BLK_W-1:0])
                    : ~(|a[cida_pkg::BLK_W-1:0]);
  endfunction : blk_edge

  function automatic logic [AW-1:0] add_addr(input logic [AW-1:0] a,
                                             input logic [AW-1:0] d);
    add_addr = AW'(a + d);
  endfunction : add_addr

  // ****************************************
  // State
  // ****************************************
  cida_pkg::cida_state_t   state_reg;
  cida_pkg::cida_mem_req_t mem_reg;
  cida_pkg::cida_dev_out_t dev_out_reg;
  logic [31:0]          w0_reg, w1_reg;
  logic [AW-1:0]        ccw_addr_reg, cur_addr_reg, list_addr_reg;
  logic [AW-1:0]        clpw_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic                 ida_act_reg, first_reg, back_reg, dir_in_reg;
  logic                 dev_in_ready_reg;
  logic [7:0]           dev_cmd_reg;
  logic [2:0]           cause_reg;
  logic                 done_evt_reg, pchk_evt_reg, cross_evt_reg;
  logic [2:0]           ctrl_reg;
  logic                 start_reg;
  logic [IRQ_W_L-1:0]   irq_stat_reg, irq_mask_reg;
  logic                 irq_reg;
  logic [31:0]          hrdata_reg;
  logic                 wr_pend_reg;
  logic [7:0]           wr_addr_reg;

  logic [7:0]  cmd;
  logic        is_tic, ida_flag, is_back, is_in, cross_now;
  logic        ida_en;
  assign cmd      = w0_reg[cida_pkg::CMD_MSB:cida_pkg::CMD_LSB];
  assign is_tic   = (cmd[3:0] == cida_pkg::CMD_TIC);
  assign is_back  = (cmd[3:0] == cida_pkg::CMD_RBACK);
  assign is_in    = is_back || (cmd[1:0] == cida_pkg::CMD_READ)
                 || (cmd[3:0] == cida_pkg::CMD_SENSE);
  assign ida_en   = ctrl_reg[cida_pkg::CTRL_IDA_EN_BIT];
  assign ida_flag = ida_en && w1_reg[cida_pkg::CCW_IDA_BIT]; // R1 R2
  assign cross_now = ida_act_reg && blk_edge(cur_addr_reg, !back_reg);

  // ****************************************
  // Channel sequencer
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg        <= cida_pkg::S_IDLE;
      mem_reg          <= '0;
      dev_out_reg      <= '0;
      w0_reg           <= '0;
      w1_reg           <= '0;
      ccw_addr_reg     <= '0;
      cur_addr_reg     <= '0;
      list_addr_reg    <= '0;
      cnt_reg          <= '0;
      ida_act_reg      <= 1'b0;
      first_reg        <= 1'b0;
      back_reg         <= 1'b0;
      dir_in_reg       <= 1'b0;
      dev_in_ready_reg <= 1'b0;
      dev_cmd_reg      <= '0;
      cause_reg        <= cida_pkg::PC_NONE;
      done_evt_reg     <= 1'b0;
      pchk_evt_reg     <= 1'b0;
      cross_evt_reg    <= 1'b0;
    end else begin
      done_evt_reg  <= 1'b0;
      pchk_evt_reg  <= 1'b0;
      cross_evt_reg <= 1'b0;
      unique case (state_reg)
        cida_pkg::S_IDLE: begin
          if (start_reg) begin
            cause_reg <= cida_pkg::PC_NONE;
            if (clpw_reg[2:0] != 3'h0) begin
              cause_reg    <= cida_pkg::PC_CLPW_ALIGN;
              pchk_evt_reg <= 1'b1;
            end else begin
              ccw_addr_reg <= clpw_reg; // R9
              mem_reg      <= '{1'b1, 1'b0, 1'b0, clpw_reg, 8'h00};
              state_reg    <= cida_pkg::S_CCW0;
            end
          end
        end
        cida_pkg::S_CCW0: begin
          if (mem_ack_i) begin
            w0_reg       <= mem_rdata_i;
            mem_reg.addr <= add_addr(ccw_addr_reg, cida_pkg::WORD_STEP);
            state_reg    <= cida_pkg::S_CCW1;
          end
        end
        cida_pkg::S_CCW1: begin
          if (mem_ack_i) begin
            w1_reg      <= mem_rdata_i;
            mem_reg.req <= 1'b0;
            state_reg   <= cida_pkg::S_DECODE;
          end
        end
        cida_pkg::S_DECODE: begin
          if (is_tic) begin
            ccw_addr_reg <= w0_reg[AW-1:0];
            mem_reg      <= '{1'b1, 1'b0, 1'b0, w0_reg[AW-1:0], 8'h00};
            state_reg    <= cida_pkg::S_CCW0;
          end else begin
            dev_cmd_reg <= cmd;
            cnt_reg     <= w1_reg[CNT_W-1:0];
            back_reg    <= is_back;
            dir_in_reg  <= is_in;
            ida_act_reg <= ida_flag;
            if (ida_flag) begin
              if (w0_reg[1:0] != 2'h0) begin // R6
                cause_reg    <= cida_pkg::PC_LIST_ALIGN;
                pchk_evt_reg <= 1'b1;
                state_reg    <= cida_pkg::S_IDLE;
              end else begin
                list_addr_reg <= w0_reg[AW-1:0]; // R4 R15
                mem_reg   <= '{1'b1, 1'b0, 1'b0, w0_reg[AW-1:0], 8'h00};
                first_reg <= 1'b1; // R10
                state_reg <= cida_pkg::S_INDIRECT_ADDR_WORD;
              end
            end else begin
              cur_addr_reg <= w0_reg[AW-1:0]; // R3 R15
              state_reg    <= cida_pkg::S_XFER;
            end
          end
        end
        cida_pkg::S_INDIRECT_ADDR_WORD: begin
          if (mem_ack_i) begin
            mem_reg.req <= 1'b0;
            if (mem_rdata_i[31:AW] != '0) begin // R6
              cause_reg    <= cida_pkg::PC_INDIRECT_ADDR_WORD_HIGH;
              pchk_evt_reg <= 1'b1;
              state_reg    <= cida_pkg::S_IDLE;
            end else if (!first_reg &&
                         !blk_edge(mem_rdata_i[AW-1:0], back_reg)) begin
              cause_reg    <= cida_pkg::PC_INDIRECT_ADDR_WORD_BLOCK; // R8
              pchk_evt_reg <= 1'b1;
              state_reg    <= cida_pkg::S_IDLE;
            end else begin
              cur_addr_reg <= mem_rdata_i[AW-1:0]; // R7 R10
              first_reg    <= 1'b0;
              state_reg    <= cida_pkg::S_XFER;
            end
          end
        end
        cida_pkg::S_XFER: begin
          if (cnt_reg == '0) begin
            state_reg <= cida_pkg::S_CHAIN; // R13
          end else if (dir_in_reg) begin
            dev_in_ready_reg <= 1'b1;
            state_reg        <= cida_pkg::S_DEV_IN;
          end else begin
            mem_reg   <= '{1'b1, 1'b0, 1'b1, cur_addr_reg, 8'h00};
            state_reg <= cida_pkg::S_MEM_RD;
          end
        end
        cida_pkg::S_MEM_RD: begin
          if (mem_ack_i) begin
            mem_reg.req <= 1'b0;
            dev_out_reg <= '{1'b1, mem_rdata_i[7:0]};
            state_reg   <= cida_pkg::S_DEV_OUT;
          end
        end
        cida_pkg::S_DEV_OUT: begin
          if (dev_end_i) begin
            dev_out_reg.valid <= 1'b0;
            state_reg         <= cida_pkg::S_CHAIN; // R13
          end else if (dev_ack_i) begin
            dev_out_reg.valid <= 1'b0;
            state_reg         <= cida_pkg::S_STEP;
          end
        end
        cida_pkg::S_DEV_IN: begin
          if (dev_end_i) begin
            dev_in_ready_reg <= 1'b0;
            state_reg        <= cida_pkg::S_CHAIN; // R13
          end else if (dev_in_valid_i) begin
            dev_in_ready_reg <= 1'b0;
            mem_reg <= '{1'b1, 1'b1, 1'b1, cur_addr_reg, dev_in_data_i};
            state_reg <= cida_pkg::S_MEM_WR;
          end
        end
        cida_pkg::S_MEM_WR: begin
          if (mem_ack_i) begin
            mem_reg.req <= 1'b0;
            state_reg   <= cida_pkg::S_STEP;
          end
        end
        cida_pkg::S_STEP: begin
          cnt_reg      <= CNT_W'(cnt_reg - 1'b1);
          cur_addr_reg <= back_reg ? add_addr(cur_addr_reg, '1) // R17
                                   : add_addr(cur_addr_reg, 24'h00_0001);
          if (cnt_reg == CNT_W'(1)) begin
            state_reg <= cida_pkg::S_CHAIN; // R13
          end else if (cross_now) begin // R12 R17
            list_addr_reg <= add_addr(list_addr_reg, cida_pkg::WORD_STEP);
            mem_reg <= '{1'b1, 1'b0, 1'b0,
                         add_addr(list_addr_reg, cida_pkg::WORD_STEP),
                         8'h00}; // R18
            cross_evt_reg <= 1'b1;
            state_reg     <= cida_pkg::S_INDIRECT_ADDR_WORD;
          end else begin
            state_reg <= cida_pkg::S_XFER; // R11
          end
        end
        cida_pkg::S_CHAIN: begin
          if (w1_reg[cida_pkg::CCW_CD_BIT] || w1_reg[cida_pkg::CCW_CC_BIT])
          begin
            ccw_addr_reg <= add_addr(ccw_addr_reg, cida_pkg::CCW_STEP);
            mem_reg <= '{1'b1, 1'b0, 1'b0,
                         add_addr(ccw_addr_reg, cida_pkg::CCW_STEP),
                         8'h00}; // R14
            state_reg <= cida_pkg::S_CCW0;
          end else begin
            dev_cmd_reg  <= '0;
            done_evt_reg <= 1'b1;
            state_reg    <= cida_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  logic addr_ph;
  assign addr_ph = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_reg  <= '0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ph && hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
      if (addr_ph && !hwrite_i) begin
        unique case (haddr_i[7:0])
          cida_pkg::CTRL_OFS:     hrdata_reg <= {29'h0, ctrl_reg};
          cida_pkg::CLPW_OFS:     hrdata_reg <= {8'h00, clpw_reg};
          cida_pkg::STATUS_OFS:   hrdata_reg <= {25'h0, cause_reg, 3'h0,
                                    state_reg != cida_pkg::S_IDLE};
          cida_pkg::CUR_ADDR_OFS: hrdata_reg <= {8'h00, cur_addr_reg};
          cida_pkg::COUNT_OFS:    hrdata_reg <= 32'(cnt_reg);
          cida_pkg::IRQ_STAT_OFS: hrdata_reg <= 32'(irq_stat_reg);
          cida_pkg::IRQ_MASK_OFS: hrdata_reg <= 32'(irq_mask_reg);
          cida_pkg::CCW_ADDR_OFS: hrdata_reg <= {8'h00, ccw_addr_reg};
          default:                hrdata_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg     <= cida_pkg::CTRL_RST;
      clpw_reg     <= '0;
      irq_mask_reg <= cida_pkg::IRQ_RST;
      start_reg    <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wr_pend_reg) begin
        unique case (wr_addr_reg)
          cida_pkg::CTRL_OFS: begin
            ctrl_reg  <= {hwdata_i[2:1], 1'b0};
            start_reg <= hwdata_i[cida_pkg::CTRL_START_BIT];
          end
          cida_pkg::CLPW_OFS:     clpw_reg <= hwdata_i[AW-1:0];
          cida_pkg::IRQ_MASK_OFS: irq_mask_reg <= hwdata_i[IRQ_W_L-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_W_L-1:0] irq_set, irq_clr, irq_stat_next;
  assign irq_set = {cross_evt_reg, pchk_evt_reg, done_evt_reg};
  assign irq_clr = (wr_pend_reg && wr_addr_reg == cida_pkg::IRQ_STAT_OFS)
                 ? hwdata_i[IRQ_W_L-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_reg <= cida_pkg::IRQ_RST;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hrdata_o       = hrdata_reg;
  assign hreadyout_o    = 1'b1;
  assign hresp_o        = 1'b0;
  assign mem_o          = mem_reg;
  assign dev_cmd_o      = dev_cmd_reg;
  assign dev_out_o      = dev_out_reg;
  assign dev_in_ready_o = dev_in_ready_reg;
  assign irq_o          = irq_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence ccw_words_s;
    state_reg == cida_pkg::S_CCW0 && mem_reg.req ##[1:1000]
    state_reg == cida_pkg::S_CCW1;
  endsequence
  sequence cross_seen_s;
    state_reg == cida_pkg::S_STEP && cnt_reg != CNT_W'(1) && cross_now;
  endsequence

  ida_flag_sel_a: assert property ( // R1
    state_reg == cida_pkg::S_DECODE && !is_tic && !ida_en
    |=> !ida_act_reg) else $error("flag used while feature off");
  list_start_a: assert property ( // R4
    state_reg == cida_pkg::S_DECODE && !is_tic && ida_flag
    && w0_reg[1:0] == 2'h0 |=> state_reg == cida_pkg::S_INDIRECT_ADDR_WORD
    && mem_reg.addr == $past(w0_reg[AW-1:0]))
    else $error("list not fetched from command address");
  direct_addr_a: assert property ( // R3
    state_reg == cida_pkg::S_DECODE && !is_tic && !ida_flag
    |=> cur_addr_reg == $past(w0_reg[AW-1:0])
    && state_reg == cida_pkg::S_XFER) else $error("direct address lost");
  first_fetch_a: assert property ( // R9
    state_reg == cida_pkg::S_IDLE && start_reg && clpw_reg[2:0] == 3'h0
    |=> mem_reg.addr == $past(clpw_reg) ##0 ccw_words_s)
    else $error("first command word not fetched");
  indirect_addr_word_high_a: assert property ( // R6
    state_reg == cida_pkg::S_INDIRECT_ADDR_WORD && mem_ack_i && mem_rdata_i[31:AW] != '0
    |=> pchk_evt_reg && cause_reg == cida_pkg::PC_INDIRECT_ADDR_WORD_HIGH)
    else $error("list word top byte not checked");
  indirect_addr_word_block_a: assert property ( // R8
    state_reg == cida_pkg::S_INDIRECT_ADDR_WORD && mem_ack_i && !first_reg
    && mem_rdata_i[31:AW] == '0 && !blk_edge(mem_rdata_i[AW-1:0], back_reg)
    |=> pchk_evt_reg ##1 state_reg == cida_pkg::S_IDLE)
    else $error("misaligned list word accepted");
  cross_fetch_a: assert property ( // R12
    cross_seen_s |=> state_reg == cida_pkg::S_INDIRECT_ADDR_WORD
    && mem_reg.addr == add_addr($past(list_addr_reg), cida_pkg::WORD_STEP))
    else $error("crossing did not fetch next list word");
  ascend_step_a: assert property ( // R11
    state_reg == cida_pkg::S_STEP && !back_reg
    |=> cur_addr_reg == add_addr($past(cur_addr_reg), 24'h00_0001))
    else $error("forward address did not ascend");
  end_on_zero_a: assert property ( // R13
    state_reg == cida_pkg::S_STEP && cnt_reg == CNT_W'(1)
    |=> state_reg == cida_pkg::S_CHAIN) else $error("count end missed");
  chain_fetch_a: assert property ( // R14
    state_reg == cida_pkg::S_CHAIN && w1_reg[cida_pkg::CCW_CC_BIT]
    |=> state_reg == cida_pkg::S_CCW0
    && mem_reg.addr == add_addr($past(ccw_addr_reg), cida_pkg::CCW_STEP))
    else $error("chained command word not fetched");

endmodule : cida_channel

// >>> hw/cida_pkg.sv
/*
 * Shared constants, types and states of the channel indirect data
 * addressing engine.
 * Assumes 24-bit real storage addresses and 64-bit command words held
 * as two big-endian 32-bit words in storage.
 */
package cida_pkg;

  // ****************************************
  // Storage and command word layout
  // ****************************************
  localparam int ADDR_W      = 24;
  localparam int BLK_W       = 11;
  localparam int CCW_IDA_POS = 37;
  localparam int CCW_IDA_BIT = 63 - CCW_IDA_POS;
  localparam int CCW_CD_BIT  = 63 - 32;
  localparam int CCW_CC_BIT  = 63 - 33;
  localparam int CCW_CNT_W   = 16;
  localparam int CMD_MSB     = 31;
  localparam int CMD_LSB     = 24;
  localparam logic [ADDR_W-1:0] WORD_STEP = 24'h00_0004;
  localparam logic [ADDR_W-1:0] CCW_STEP  = 24'h00_0008;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [3:0] CMD_TIC   = 4'h8;
  localparam logic [3:0] CMD_RBACK = 4'hC;
  localparam logic [3:0] CMD_SENSE = 4'h4;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_CTRL  = 2'h3;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CLPW_OFS     = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] CUR_ADDR_OFS = 8'h0C;
  localparam logic [7:0] COUNT_OFS    = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] CCW_ADDR_OFS = 8'h1C;
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_IDA_EN_BIT = 1;
  localparam int CTRL_EXT_BIT    = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_CAUSE_LSB  = 4;
  localparam int IRQ_W           = 3;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_PCHK_BIT    = 1;
  localparam int IRQ_CROSS_BIT   = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ****************************************
  // Program check causes
  // ****************************************
  localparam logic [2:0] PC_NONE       = 3'h0;
  localparam logic [2:0] PC_CLPW_ALIGN = 3'h1;
  localparam logic [2:0] PC_LIST_ALIGN = 3'h2;
  localparam logic [2:0] PC_INDIRECT_ADDR_WORD_HIGH  = 3'h3;
  localparam logic [2:0] PC_INDIRECT_ADDR_WORD_BLOCK = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE, S_CCW0, S_CCW1, S_DECODE, S_INDIRECT_ADDR_WORD, S_XFER,
    S_MEM_RD, S_DEV_OUT, S_DEV_IN, S_MEM_WR, S_STEP, S_CHAIN
  } cida_state_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic              is_byte;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } cida_mem_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cida_dev_out_t;

endpackage : cida_pkg
